// file: rtl/wakeup_measure_compare.v
// amplitude and phase wake-up comparator with running averages and views
// assumes measurement strobes come from logic on CORE_CLK; trim code is static
//
// Added by the designer: the strobed register port.

`timescale 1ns/1ps
`include "wakeup_measure_compare_defs.vh"

module wakeup_measure_compare (
  input  wire       CORE_CLK,
  input  wire       RESET_N,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR_EN,
  input  wire       RD_EN,
  output reg  [7:0] RDATA,
  input  wire       AMP_VALID,
  input  wire [7:0] AMP_RESULT,
  input  wire       PHASE_VALID,
  input  wire [7:0] PHASE_RESULT,
  input  wire [2:0] TRIM_CODE,
  output reg  [3:0] DRES_TIME,
  output reg        AMP_WAKE,
  output reg        PHASE_WAKE,
  output reg        IRQ
);

  // channel 0 is amplitude, channel 1 is phase
  localparam NCH = 2;

  // flat views of the per-channel registers, one driver per slice
  wire [8*NCH-1:0] cfg_r;
  wire [8*NCH-1:0] ref_r;
  wire [8*NCH-1:0] avg_r;
  wire [8*NCH-1:0] last_r;
  wire [NCH-1:0]   hit;
  reg  [1:0]       status_r;
  reg  [1:0]       status_nxt;
  reg  [1:0]       enable_r;
  reg  [2:0]       trim_meta_r;
  reg  [2:0]       trim_r;
  reg  [7:0]       rdata_nxt;

  // per-channel register offsets
  function [7:0] cfg_off;
    input integer ch;
    begin
      cfg_off = (ch == 0) ? `OFF_AMP_CFG : `OFF_PH_CFG;
    end
  endfunction

  function [7:0] ref_off;
    input integer ch;
    begin
      ref_off = (ch == 0) ? `OFF_AMP_REF : `OFF_PH_REF;
    end
  endfunction

  // weight code to right-shift amount: 2,3,4,5 for weights 4,8,16,32
  function [2:0] wgt_shift;
    input [1:0] code;
    begin
      wgt_shift = `WGT_BASE_SHIFT + {1'b0, code};
    end
  endfunction

  wire       valid [0:NCH-1];
  wire [7:0] sample [0:NCH-1];
  assign valid[0]  = AMP_VALID;
  assign valid[1]  = PHASE_VALID;
  assign sample[0] = AMP_RESULT;
  assign sample[1] = PHASE_RESULT;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      reg  [7:0]        cfg_ch_r;
      reg  [7:0]        ref_ch_r;
      reg  [7:0]        avg_ch_r;
      reg  [7:0]        last_ch_r;
      wire [7:0]        cfg  = cfg_ch_r;
      wire [7:0]        avg  = avg_ch_r;
      wire [3:0]        thr  = cfg[`CFG_THR_HI:`CFG_THR_LO];
      wire              incl = cfg[`CFG_INCL_BIT];
      wire [1:0]        wgt  = cfg[`CFG_WGT_HI:`CFG_WGT_LO];
      // reference is either the programmed value or the running average
      wire [7:0]        refv = cfg[`CFG_REFSEL_BIT] ? avg : ref_ch_r;
      wire signed [8:0] dref = $signed({1'b0, sample[ch]}) - $signed({1'b0, refv});
      wire [8:0]        mag  = dref[8] ? (9'h000 - dref) : dref;
      // arithmetic shift: a negative step rounds toward minus infinity, never to zero
      wire signed [8:0] davg = $signed({1'b0, sample[ch]}) - $signed({1'b0, avg});
      wire signed [8:0] step = davg >>> wgt_shift(wgt);
      wire              upd;

      assign hit[ch] = valid[ch] & (mag > {5'h00, thr});
      // a triggering sample only moves the average when include is set
      assign upd     = valid[ch] & (~hit[ch] | incl);

      // each channel owns its slice of the flat views
      assign cfg_r[8*ch +: 8]  = cfg_ch_r;
      assign ref_r[8*ch +: 8]  = ref_ch_r;
      assign avg_r[8*ch +: 8]  = avg_ch_r;
      assign last_r[8*ch +: 8] = last_ch_r;

      // config and reference registers
      always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          cfg_ch_r <= `REG_RESET;
          ref_ch_r <= `REG_RESET;
        end else if (WR_EN) begin
          if (ADDR == cfg_off(ch))
            cfg_ch_r <= WDATA;
          if (ADDR == ref_off(ch))
            ref_ch_r <= WDATA;
        end
      end

      // average and latest result follow the front end, never the bus
      always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          avg_ch_r  <= `REG_RESET;
          last_ch_r <= `REG_RESET;
        end else begin
          if (valid[ch])
            last_ch_r <= sample[ch];
          if (upd)
            avg_ch_r  <= avg + step[7:0];
        end
      end
    end
  endgenerate

  // sticky status: a new event wins over a clear in the same cycle
  always @* begin
    status_nxt = status_r;
    if (WR_EN && ADDR == `OFF_IRQ_CLEAR)
      status_nxt = status_nxt & ~WDATA[1:0];
    status_nxt = status_nxt | hit;
  end

  // event registers, interrupt level and wake pulses
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_r   <= 2'h0;
      enable_r   <= 2'h0;
      IRQ        <= 1'b0;
      AMP_WAKE   <= 1'b0;
      PHASE_WAKE <= 1'b0;
    end else begin
      status_r   <= status_nxt;
      if (WR_EN && ADDR == `OFF_IRQ_ENABLE)
        enable_r <= WDATA[1:0];
      IRQ        <= |(status_nxt & ((WR_EN && ADDR == `OFF_IRQ_ENABLE) ? WDATA[1:0] : enable_r));
      AMP_WAKE   <= hit[0];
      PHASE_WAKE <= hit[1];
    end
  end

  // restore timing: only the upper nibble is stored, low bits read zero
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N)
      DRES_TIME <= 4'h0;
    else if (WR_EN && ADDR == `OFF_DRES_TIME)
      DRES_TIME <= WDATA[`DRES_HI:`DRES_LO];
  end

  // trim code comes from another domain, two flops before use
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trim_meta_r <= `TRIM_RESET;
      trim_r      <= `TRIM_RESET;
    end else begin
      trim_meta_r <= TRIM_CODE;
      trim_r      <= trim_meta_r;
    end
  end

  // read mux; unmapped and write-only locations read zero
  always @* begin
    case (ADDR)
      `OFF_AMP_CFG:    rdata_nxt = cfg_r[7:0];
      `OFF_AMP_REF:    rdata_nxt = ref_r[7:0];
      `OFF_AMP_AVG:    rdata_nxt = avg_r[7:0];
      `OFF_AMP_LAST:   rdata_nxt = last_r[7:0];
      `OFF_PH_CFG:     rdata_nxt = cfg_r[15:8];
      `OFF_PH_REF:     rdata_nxt = ref_r[15:8];
      `OFF_PH_AVG:     rdata_nxt = avg_r[15:8];
      `OFF_PH_LAST:    rdata_nxt = last_r[15:8];
      `OFF_IRQ_STATUS: rdata_nxt = {6'h00, status_r};
      `OFF_IRQ_ENABLE: rdata_nxt = {6'h00, enable_r};
      `OFF_DRES_TIME:  rdata_nxt = {DRES_TIME, 4'h0};
      `OFF_TRIM_VIEW:  rdata_nxt = {5'h00, trim_r};
      default:         rdata_nxt = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N)
      RDATA <= 8'h00;
    else
      RDATA <= RD_EN ? rdata_nxt : 8'h00;
  end

endmodule // wakeup_measure_compare

// file: inc/wakeup_measure_compare_defs.vh
// constants for the amplitude/phase wake-up compare block
// assumes an 8-bit register port whose bit 7 selects register space B
// How it works
// - phase threshold is config bits 7:4
// - config bit 3 includes triggering sample
// - weight code 00..11 selects 4,8,16,32
// - config bit 0 picks average as reference
// - phase reference value, read-write, resets zero
// - phase average view, read-only, resets zero
// - latest phase result view, read-only
// - amplitude average view, read-only, resets zero
// - latest amplitude result view, read-only
// - restore timing field in bits 7:4
// - three-bit oscillator trim code readout, centre 011b
// - trim readout in space B, bits 7:3 zero
// - amplitude config mirrors phase config layout
// - amplitude reference value, read-write, resets zero
`ifndef WAKEUP_MEASURE_COMPARE_DEFS_VH
`define WAKEUP_MEASURE_COMPARE_DEFS_VH

// space A offsets
`define OFF_AMP_CFG      8'h33
`define OFF_AMP_REF      8'h34
`define OFF_AMP_AVG      8'h35
`define OFF_AMP_LAST     8'h36
`define OFF_PH_CFG       8'h37
`define OFF_PH_REF       8'h38
`define OFF_PH_AVG       8'h39
`define OFF_PH_LAST      8'h3A
// wake event registers
`define OFF_IRQ_STATUS   8'h3C
`define OFF_IRQ_CLEAR    8'h3D
`define OFF_IRQ_ENABLE   8'h3E
// space B offsets (bit 7 set)
`define OFF_DRES_TIME    8'hB8
`define OFF_TRIM_VIEW    8'hB9

// config field positions
`define CFG_THR_HI       7
`define CFG_THR_LO       4
`define CFG_INCL_BIT     3
`define CFG_WGT_HI       2
`define CFG_WGT_LO       1
`define CFG_REFSEL_BIT   0
// smallest weight is 4, a shift of 2
`define WGT_BASE_SHIFT   3'h2

// restore timing field
`define DRES_HI          7
`define DRES_LO          4

// status bit positions
`define ST_AMP_BIT       0
`define ST_PH_BIT        1

`define REG_RESET        8'h00
`define TRIM_RESET       3'h0

`endif

// file: test/wakeup_measure_compare_chk.sv
// checker for the wake-up compare block, bound to its top-level ports
// assumes the offsets of the shared defines header
`timescale 1ns/1ps
`include "wakeup_measure_compare_defs.vh"
module wakeup_measure_compare_chk (
  input wire       CORE_CLK, RESET_N, WR_EN, RD_EN, AMP_VALID, PHASE_VALID,
  input wire       AMP_WAKE, PHASE_WAKE, IRQ,
  input wire [7:0] ADDR, WDATA, RDATA,
  input wire [3:0] DRES_TIME
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // read data stands only in the cycle after a read strobe
  chk_rdata_idle: assert property (!RD_EN |=> RDATA == 8'h00)
    else $error("read data not idle");
  chk_trim_upper: assert property (RD_EN && ADDR == `OFF_TRIM_VIEW |=> RDATA[7:3] == 5'h00)
    else $error("trim view upper bits set");
  chk_restore_load: assert property (WR_EN && ADDR == `OFF_DRES_TIME
    |=> {DRES_TIME, 4'h0} == ($past(WDATA) & 8'hF0)) else $error("restore time not loaded");
  chk_restore_hold: assert property (!(WR_EN && ADDR == `OFF_DRES_TIME)
    |=> $stable(DRES_TIME)) else $error("restore time moved");
  // a wake pulse always has a sample one edge before it
  chk_amp_pulse: assert property (!AMP_VALID |=> !AMP_WAKE)
    else $error("amp wake without sample");
  chk_phase_pulse: assert property (!PHASE_VALID |=> !PHASE_WAKE)
    else $error("phase wake without sample");
  chk_irq_rise: assert property ($rose(IRQ) |-> $past(AMP_VALID) || $past(PHASE_VALID)
    || $past(WR_EN)) else $error("irq rose without cause");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(WR_EN))
    else $error("irq fell without write");
endmodule // wakeup_measure_compare_chk

bind wakeup_measure_compare wakeup_measure_compare_chk chk_i (.CORE_CLK(CORE_CLK),
  .RESET_N(RESET_N), .WR_EN(WR_EN), .RD_EN(RD_EN), .AMP_VALID(AMP_VALID),
  .PHASE_VALID(PHASE_VALID), .AMP_WAKE(AMP_WAKE), .PHASE_WAKE(PHASE_WAKE), .IRQ(IRQ),
  .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .DRES_TIME(DRES_TIME));

// file: test/meas_front_end.sv
// stand-in for the analog front end: one-cycle result strobes, static trim
// assumes send() is called from one process only
`timescale 1ns/1ps
module meas_front_end (
  input  wire       clk,
  output reg        amp_valid    = 1'b0,
  output reg  [7:0] amp_result   = 8'h00,
  output reg        phase_valid  = 1'b0,
  output reg  [7:0] phase_result = 8'h00,
  output wire [2:0] trim_code
);
  assign trim_code = 3'h5; // arbitrary static trim setting
  // results are garbage outside the strobe, so the inverse is shown then
  task send(input bit ph, input [7:0] v);
    @(posedge clk);
    phase_valid  <= ph;
    amp_valid    <= !ph;
    phase_result <= v;
    amp_result   <= v;
    @(posedge clk);
    phase_valid  <= 1'b0;
    amp_valid    <= 1'b0;
    phase_result <= ~v;
    amp_result   <= ~v;
  endtask
endmodule // meas_front_end

// file: test/tb.sv
// self-checking bench: register tasks, front-end stand-in, bound checker
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  wire [7:0] rdata, ares, pres;
  wire       av, pv, awake, pwake, irq;
  wire [2:0] trim;
  wire [3:0] dres;
  int        errors = 0;
  int        checks = 0;
  int        av_e [2];
  reg  [7:0] cfg_e [2] = '{8'h00, 8'h00};
  reg  [7:0] ref_e [2] = '{8'h00, 8'h00};
  reg  [1:0] st_e = 2'b00;
  reg  [1:0] en_e = 2'b10;
  reg  [7:0] rz [14] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3C,
                         8'h3D, 8'h3E, 8'h50, 8'hB8, 8'h7F};
  reg  [7:0] ro [6] = '{8'h35, 8'h36, 8'h39, 8'h3A, 8'h3C, 8'h50};
  initial forever #4 clk = ~clk;
  meas_front_end fe (.clk(clk), .amp_valid(av), .amp_result(ares), .phase_valid(pv),
    .phase_result(pres), .trim_code(trim));
  wakeup_measure_compare uut (.CORE_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR_EN(wr), .RD_EN(rd), .RDATA(rdata), .AMP_VALID(av), .AMP_RESULT(ares),
    .PHASE_VALID(pv), .PHASE_RESULT(pres), .TRIM_CODE(trim), .DRES_TIME(dres),
    .AMP_WAKE(awake), .PHASE_WAKE(pwake), .IRQ(irq));
  task wrr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task setc(input int c, input [7:0] g, input [7:0] r);
    cfg_e[c] = g;
    ref_e[c] = r;
    wrr(c ? 8'h37 : 8'h33, g);
    wrr(c ? 8'h38 : 8'h34, r);
  endtask
  // expected compare and average step, worked out before the sample goes in
  task meas(input int c, input [7:0] s);
    int r;
    int v;
    bit hit;
    v = s;
    r = cfg_e[c][0] ? av_e[c] : ref_e[c];
    hit = ((v > r) ? v - r : r - v) > cfg_e[c][7:4];
    if (!hit || cfg_e[c][3]) av_e[c] += (v - av_e[c]) >>> (2 + cfg_e[c][2:1]);
    st_e[c] = st_e[c] | hit;
    fe.send(c[0], s);
    #1 `CHK(c[0] ? pwake : awake, hit)
    `CHK(irq, |(st_e & en_e))
    rdc(c ? 8'h3A : 8'h36, s);
    rdc(c ? 8'h39 : 8'h35, av_e[c][7:0]);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rz[i]) rdc(rz[i], 8'h00);
    rdc(8'hB9, 8'h05);
    // read-only and unmapped places ignore writes
    foreach (ro[i]) begin
      wrr(ro[i], 8'hFF);
      rdc(ro[i], 8'h00);
    end
    wrr(8'hB8, 8'hA0);
    #1 `CHK(dres, 4'hA)
    rdc(8'hB8, 8'hA0);
    wrr(8'hB8, 8'h00);
    wrr(8'h3E, 8'h02);
    // threshold 2 against fixed reference, trigger sample left out
    setc(1, 8'h20, 8'h10);
    meas(1, 8'h12);
    meas(1, 8'h13);
    meas(1, 8'h0E);
    for (int c = 0; c < 2; c++)
      for (int w = 0; w < 4; w++) begin
        setc(c, {4'h3, 1'b1, w[1:0], 1'b1}, 8'h00);
        meas(c, 8'hF0);
        meas(c, 8'h05);
      end
    rdc(8'h3C, {6'h00, st_e});
    wrr(8'h3D, 8'h02);
    st_e[1] = 1'b0;
    #1 `CHK(irq, 1'b0)
    wrr(8'h3E, 8'h01);
    #1 `CHK(irq, 1'b1) // amp status was masked until now
    final_report;
  end
  initial begin
    #300000;
    errors++;
    final_report;
  end
endmodule // tb
